/* File: rtl/serial_port.sv */
`timescale 1ns/10ps
`include "serial_port_cfg.svh"

module serial_port
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       timer1_overflow,
  input  wire logic       rx_pin,
  output logic            tx_pin
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [7:0] serial_buffer_r;
  logic [1:0] mode_r;
  logic       multiproc_filter_enable;
  logic       rx_enable_r;
  logic       tx_ninth_bit;
  logic       rx_ninth_bit;
  logic       tx_done_flag;
  logic       rx_done_flag;
  logic       baud_double;
  logic       internal_baud_select;
  logic       tick16;
  logic [7:0] serial_control_reg;
  logic       ten_bit;

  assign ten_bit = (mode_r == `MODE_TEN_BIT);
  assign serial_control_reg = {mode_r, multiproc_filter_enable, rx_enable_r,
                               tx_ninth_bit, rx_ninth_bit, tx_done_flag,
                               rx_done_flag};

  // --------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------
  logic wr_buffer;
  logic wr_control;
  logic wr_baud;
  logic [7:0] rd_mux;

  assign wr_buffer  = reg_write & (reg_addr == `ADDR_SERIAL_BUFFER);
  assign wr_control = reg_write & (reg_addr == `ADDR_SERIAL_CONTROL);
  assign wr_baud    = reg_write & (reg_addr == `ADDR_BAUD_CONTROL);
  assign rd_mux =
    (reg_addr == `ADDR_SERIAL_BUFFER)  ? serial_buffer_r :
    (reg_addr == `ADDR_SERIAL_CONTROL) ? serial_control_reg :
    (reg_addr == `ADDR_BAUD_CONTROL)   ?
      {6'h00, internal_baud_select, baud_double} : `BYTE_ZERO;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      reg_rdata <= `BYTE_ZERO;
    else
      reg_rdata <= reg_read ? rd_mux : `BYTE_ZERO;
  end

  baud_source u_baud
  (
    .mclk                 (mclk),
    .resetn               (resetn),
    .internal_baud_select (internal_baud_select),
    .baud_double          (baud_double),
    .timer1_overflow      (timer1_overflow),
    .tick16               (tick16)
  );

  // --------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------
  // The transmit divide-by-16 counter runs freely on the tick.
  logic [3:0] tx_div_r;
  logic       tx_roll;
  logic       tx_req_r;
  logic       tx_send_r;
  logic       tx_data_r;
  logic [8:0] tx_shift_r;
  logic [3:0] tx_rolls_r;
  logic       tx_end;
  logic       tx_done_set;

  assign tx_roll = tick16 & (tx_div_r == `TICK_COUNT_LAST);
  // Rollovers are counted from the write, so the end is at rollover 10 or 11.
  assign tx_end = tx_roll & tx_send_r &
                  (tx_rolls_r == (ten_bit ? `TX_BITS_10 : `TX_BITS_11)
                   - 4'h1);
  assign tx_done_set = tx_end;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      tx_div_r   <= 4'h0;
      tx_req_r   <= 1'b0;
      tx_send_r  <= 1'b0;
      tx_data_r  <= 1'b0;
      tx_shift_r <= `RX_SHIFT_ONES;
      tx_rolls_r <= 4'h0;
      tx_pin     <= 1'b1;
    end
    else
    begin
      if (tick16)
        tx_div_r <= tx_div_r + 4'h1;
      if (wr_buffer)
      begin
        // A 1 or the ninth bit sits above the data byte.
        tx_shift_r <= {ten_bit ? 1'b1 : tx_ninth_bit, reg_wdata};
        tx_req_r   <= 1'b1;
        tx_rolls_r <= 4'h0;
        tx_send_r  <= 1'b0;
        tx_data_r  <= 1'b0;
      end
      else if (tx_roll)
      begin
        if (tx_req_r)
        begin
          // Send starts on a rollover, not on the write.
          tx_req_r   <= 1'b0;
          tx_send_r  <= 1'b1;
          tx_rolls_r <= 4'h1;
          tx_pin     <= 1'b0;
        end
        else if (tx_end)
        begin
          tx_send_r <= 1'b0;
          tx_data_r <= 1'b0;
          tx_pin    <= 1'b1;
        end
        else if (tx_send_r)
        begin
          tx_rolls_r <= tx_rolls_r + 4'h1;
          if (!tx_data_r)
          begin
            tx_data_r <= 1'b1;
            tx_pin    <= tx_shift_r[0];
          end
          else
          begin
            // Eleven-bit frames shift a stop 1 in first, then zeroes.
            tx_shift_r <= {(!ten_bit && tx_rolls_r == 4'h2), tx_shift_r[8:1]};
            tx_pin     <= (ten_bit && tx_rolls_r == 4'h9) ? 1'b1 : tx_shift_r[1];
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------
  logic       rx_s1_r;
  logic       rx_s2_r;
  logic       rx_prev_r;
  serial_port_pkg::rx_state_t rx_state_r;
  logic [3:0] rx_div_r;
  logic [8:0] rx_shift_r;
  logic [2:0] vote_r;
  logic       rx_first_r;
  logic       rx_fall;
  logic       vote_bit;
  logic       bit_done;
  logic       final_shift;
  logic       accept;
  logic       frame_bit9;

  // Majority of the three samples taken mid bit.
  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : majority3

  assign rx_fall  = rx_prev_r & ~rx_s2_r;
  assign vote_bit = majority3(vote_r);
  assign bit_done = tick16 & (rx_div_r == `SAMPLE_DONE);
  // The start bit, now in bit 0, marks the tenth frame bit arriving.
  assign final_shift = bit_done & ~rx_first_r & ~rx_shift_r[0];
  // Stop bit in ten-bit frames, ninth data bit otherwise.
  assign frame_bit9 = vote_bit;
  assign accept = final_shift & ~rx_done_flag &
                  (~multiproc_filter_enable | frame_bit9);

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      rx_s1_r    <= 1'b1;
      rx_s2_r    <= 1'b1;
      rx_prev_r  <= 1'b1;
      rx_state_r <= serial_port_pkg::RX_IDLE;
      rx_div_r   <= 4'h0;
      rx_shift_r <= `RX_SHIFT_ONES;
      vote_r     <= 3'h7;
      rx_first_r <= 1'b0;
    end
    else
    begin
      rx_s1_r   <= rx_pin;
      rx_s2_r   <= rx_s1_r;
      if (tick16)
        rx_prev_r <= rx_s2_r;
      if (tick16)
        rx_div_r <= rx_div_r + 4'h1;
      if (tick16 && rx_div_r == `SAMPLE_A)
        vote_r[0] <= rx_s2_r;
      if (tick16 && rx_div_r == `SAMPLE_B)
        vote_r[1] <= rx_s2_r;
      if (tick16 && rx_div_r == `SAMPLE_C)
        vote_r[2] <= rx_s2_r;
      case (rx_state_r)
        serial_port_pkg::RX_IDLE:
        begin
          if (tick16 && rx_fall && rx_enable_r)
          begin
            rx_div_r   <= 4'h1;
            rx_shift_r <= `RX_SHIFT_ONES;
            rx_first_r <= 1'b1;
            rx_state_r <= serial_port_pkg::RX_FRAME;
          end
        end
        serial_port_pkg::RX_FRAME:
        begin
          if (bit_done)
          begin
            rx_first_r <= 1'b0;
            if (rx_first_r && vote_bit)
              rx_state_r <= serial_port_pkg::RX_IDLE;
            else if (final_shift)
            begin
              rx_shift_r <= {vote_bit, rx_shift_r[8:1]};
              // Ten-bit frames end here; eleven-bit wait out the stop bit.
              rx_state_r <= ten_bit ? serial_port_pkg::RX_IDLE
                                    : serial_port_pkg::RX_HOLD;
            end
            else
              rx_shift_r <= {vote_bit, rx_shift_r[8:1]};
          end
        end
        serial_port_pkg::RX_HOLD:
        begin
          if (bit_done)
            rx_state_r <= serial_port_pkg::RX_IDLE;
        end
        default:
          rx_state_r <= serial_port_pkg::RX_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Control state and flags
  // --------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      serial_buffer_r         <= `BYTE_ZERO;
      mode_r                  <= 2'h0;
      multiproc_filter_enable <= 1'b0;
      rx_enable_r             <= 1'b0;
      tx_ninth_bit            <= 1'b0;
      rx_ninth_bit            <= 1'b0;
      tx_done_flag            <= 1'b0;
      rx_done_flag            <= 1'b0;
      baud_double             <= 1'b0;
      internal_baud_select    <= 1'b0;
    end
    else
    begin
      if (wr_control)
      begin
        mode_r <= reg_wdata[`SC_MODE_HI:`SC_MODE_LO];
        multiproc_filter_enable <= reg_wdata[`SC_MULTIPROC];
        rx_enable_r  <= reg_wdata[`SC_RX_EN];
        tx_ninth_bit <= reg_wdata[`SC_TX_NINTH];
        rx_ninth_bit <= reg_wdata[`SC_RX_NINTH];
        tx_done_flag <= reg_wdata[`SC_TX_DONE];
        rx_done_flag <= reg_wdata[`SC_RX_DONE];
      end
      if (wr_baud)
      begin
        baud_double          <= reg_wdata[`BC_DOUBLE];
        internal_baud_select <= reg_wdata[`BC_INTERNAL];
      end
      // Hardware sets win over a software write in the same cycle.
      if (tx_done_set)
        tx_done_flag <= 1'b1;
      if (accept)
      begin
        serial_buffer_r <= rx_shift_r[8:1];
        rx_ninth_bit    <= frame_bit9;
        rx_done_flag    <= 1'b1;
      end
    end
  end

endmodule : serial_port

/* File: inc/serial_port_cfg.svh */
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_SERIAL_BUFFER  8'h00
`define ADDR_SERIAL_CONTROL 8'h01
`define ADDR_BAUD_CONTROL   8'h02

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define SC_RX_DONE   0
`define SC_TX_DONE   1
`define SC_RX_NINTH  2
`define SC_TX_NINTH  3
`define SC_RX_EN     4
`define SC_MULTIPROC 5
`define SC_MODE_LO   6
`define SC_MODE_HI   7
`define BC_DOUBLE    0
`define BC_INTERNAL  1

// ----------------------------------------------------------------------
// Timing and reset values
// ----------------------------------------------------------------------
`define INT_DIV_COUNT    7'd78
`define INT_DIV_LAST     7'd77
`define TICK_COUNT_LAST  4'hF
`define SAMPLE_A         4'h6
`define SAMPLE_B         4'h7
`define SAMPLE_C         4'h8
`define SAMPLE_DONE      4'h9
`define RX_SHIFT_ONES    9'h1FF
`define TX_BITS_10       4'hA
`define TX_BITS_11       4'hB
`define MODE_TEN_BIT     2'h1
`define BYTE_ZERO        8'h00

`endif

/* File: inc/serial_port_pkg.sv */
package serial_port_pkg;

  typedef enum logic [2:0]
  {
    RX_IDLE  = 3'b001,
    RX_FRAME = 3'b010,
    RX_HOLD  = 3'b100
  } rx_state_t;

endpackage : serial_port_pkg

/* File: rtl/baud_source.sv */
`timescale 1ns/10ps
`include "serial_port_cfg.svh"

// ----------------------------------------------------------------------
// Oversampling tick source
// ----------------------------------------------------------------------
// Produces one tick per sixteenth of a bit time.
module baud_source
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic internal_baud_select,
  input  wire logic baud_double,
  input  wire logic timer1_overflow,
  output logic      tick16
);

  logic [6:0] div_r;
  logic       half_r;
  logic       div_wrap;
  logic       pre_tick;

  // The internal divider wraps every 78 clocks.
  assign div_wrap = (div_r == `INT_DIV_LAST);
  // Timer 1 overflows pass straight to the halver.
  assign pre_tick = internal_baud_select ? div_wrap : timer1_overflow;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      div_r  <= 7'h00;
      half_r <= 1'b0;
      tick16 <= 1'b0;
    end
    else
    begin
      div_r  <= div_wrap ? 7'h00 : div_r + 7'h01;
      if (pre_tick)
        half_r <= ~half_r;
      // Doubling skips the divide by two.
      tick16 <= pre_tick & (baud_double | half_r);
    end
  end

endmodule : baud_source

/* File: verification/serial_port_sva.sv */
`timescale 1ns/10ps
`include "serial_port_cfg.svh"

// --------------------
// Port checker
// --------------------
module serial_port_sva
(
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       timer1_overflow,
  input wire logic       tx_pin
);
  logic [1:0] baud_r;
  logic [7:0] ctl_r;
  logic [1:0] seen_r;
  logic [5:0] ov_r;
  logic       tx_q_r;
  logic       rd_ctl_r;
  wire        wr_ctl = reg_write && reg_addr == `ADDR_SERIAL_CONTROL;
  wire        x1     = baud_r == 2'h1;

  // Counts overflow pulses since the line last changed.
  always_ff @(posedge mclk)
  begin
    tx_q_r   <= tx_pin;
    rd_ctl_r <= reg_read && reg_addr == `ADDR_SERIAL_CONTROL;
    if (!resetn || tx_pin != tx_q_r)
      ov_r <= 6'h00;
    else if (timer1_overflow && ov_r != 6'h3F)
      ov_r <= ov_r + 6'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      baud_r <= 2'h0;
      ctl_r  <= 8'h00;
      seen_r <= 2'h0;
    end
    else
    begin
      if (reg_write && reg_addr == `ADDR_BAUD_CONTROL)
        baud_r <= reg_wdata[1:0];
      if (wr_ctl)
        ctl_r <= reg_wdata;
      if (wr_ctl)
        seen_r <= seen_r & reg_wdata[1:0];
      else if (rd_ctl_r)
        seen_r <= seen_r | reg_rdata[1:0];
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  a_idle_after_reset:
    assert property ($rose(resetn) |-> tx_pin)
      else $error("line not idle high after reset");
  a_read_stands:
    assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
  a_unmapped_zero:
    assert property (reg_read && reg_addr > `ADDR_BAUD_CONTROL
                     |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
  a_baud_readback:
    assert property (reg_read && reg_addr == `ADDR_BAUD_CONTROL
                     |=> reg_rdata[1:0] == baud_r)
      else $error("rate select read back wrong");
  a_ctl_readback:
    assert property (rd_ctl_r |-> reg_rdata[7:3] == ctl_r[7:3])
      else $error("control bits read back wrong");
  a_flags_sticky:
    assert property (rd_ctl_r |-> (reg_rdata[1:0] & seen_r) == seen_r)
      else $error("done flag cleared by hardware");
  a_bit_width:
    assert property (x1 && tx_pin != tx_q_r |-> ov_r >= 6'h0F)
      else $error("line changed inside a bit time");
  a_tx_starts:
    assert property (x1 && tx_pin && reg_write
                     && reg_addr == `ADDR_SERIAL_BUFFER |-> ##[1:40] !tx_pin)
      else $error("start bit missing after buffer write");

  c_tx_start: cover property (x1 && $fell(tx_pin));
  c_rx_done: cover property (rd_ctl_r && reg_rdata[0]);
  c_rx_ninth: cover property (rd_ctl_r && reg_rdata[2]);
endmodule : serial_port_sva

bind serial_port serial_port_sva i_sva
(
  .mclk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .timer1_overflow, .tx_pin
);

/* File: verification/remote_node.sv */
`timescale 1ns/10ps

// --------------------
// Remote serial node
// --------------------
module remote_node
(
  input  wire logic mclk,
  input  wire logic tx_pin,
  output logic      rx_line
);
  int bit_cyc = 32;

  initial rx_line = 1'b1;

  // One bit may carry a two-cycle glitch to probe the voting.
  task automatic send(input logic [10:0] b, input int n, input int gl);
    for (int i = 0; i < n; i++)
      for (int c = 0; c < bit_cyc; c++)
      begin
        rx_line <= b[i] ^ (i == gl && c >= 16 && c < 18);
        @(posedge mclk);
      end
  endtask : send

  task automatic idle(input int n);
    rx_line <= 1'b1;
    repeat (n) @(posedge mclk);
  endtask : idle

  // Returns at the middle of the last bit taken.
  task automatic recv(input int n, output logic [10:0] b, output bit ok);
    ok = 1'b0;
    b  = 11'h000;
    for (int t = 0; t < 24 * bit_cyc && !ok; t++)
    begin
      @(negedge mclk);
      ok = !tx_pin;
    end
    repeat (bit_cyc / 2) @(negedge mclk);
    for (int i = 0; i < n; i++)
    begin
      if (i > 0)
        repeat (bit_cyc) @(negedge mclk);
      b[i] = tx_pin;
    end
  endtask : recv
endmodule : remote_node

/* File: verification/tb.sv */
`timescale 1ns/10ps
`include "serial_port_cfg.svh"

module tb;
  logic        mclk            = 1'b0;
  logic        resetn          = 1'b0;
  logic [7:0]  reg_addr        = 8'h00;
  logic [7:0]  reg_wdata       = 8'h00;
  logic        reg_write       = 1'b0;
  logic        reg_read        = 1'b0;
  logic        timer1_overflow = 1'b0;
  logic [7:0]  reg_rdata;
  logic        rx_line;
  logic        tx_pin;
  logic [7:0]  d;
  logic [10:0] f;
  bit          ok;
  int          err_count = 0;
  int          cmp_count = 0;
  int          bit_tab [4] = '{64, 32, 2496, 1248};

  always #10 mclk = ~mclk;
  always @(posedge mclk) timer1_overflow <= ~timer1_overflow;

  serial_port i_dut
  (
    .mclk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .timer1_overflow, .rx_pin (rx_line), .tx_pin
  );
  remote_node i_node (.mclk, .tx_pin, .rx_line);

  // --------------------
  // Access tasks
  // --------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
    @(posedge mclk);
  endtask : rd

  task automatic chk(input string nm, input logic [10:0] e,
                     input logic [10:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // Sends a byte; the done flag must rise between last data and stop.
  task automatic tx_frame(input logic [7:0] v, input logic n9, input int nb);
    logic [10:0] e;
    e = (nb == 10) ? {2'h0, v, 1'b0} : {1'b0, n9, v, 1'b0};
    wr(`ADDR_SERIAL_BUFFER, v);
    i_node.recv(nb - 1, f, ok);
    @(posedge mclk);
    if (!ok)
    begin
      err_count++;
      stop_test();
    end
    chk("tx frame", e, f);
    rd(`ADDR_SERIAL_CONTROL, d);
    chk("tx done early", 11'h000, d[1]);
    repeat (i_node.bit_cyc) @(negedge mclk);
    chk("stop bit", 11'h001, tx_pin);
    @(posedge mclk);
    rd(`ADDR_SERIAL_CONTROL, d);
    chk("tx done", 11'h001, d[1]);
  endtask : tx_frame

  task automatic rx_chk(input logic [7:0] b, input logic [2:0] c);
    rd(`ADDR_SERIAL_BUFFER, d);
    chk("rx buffer", b, d);
    rd(`ADDR_SERIAL_CONTROL, d);
    chk("rx flags", c, d[2:0]);
  endtask : rx_chk

  // --------------------
  // Test sequence
  // --------------------
  initial
  begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    for (int s = 0; s < 4; s++)
    begin
      wr(`ADDR_BAUD_CONTROL, 8'(s));
      wr(`ADDR_SERIAL_CONTROL, 8'h50);
      i_node.bit_cyc = bit_tab[s];
      tx_frame(8'hA5 ^ 8'(s), 1'b0, 10);
    end
    rd(`ADDR_BAUD_CONTROL, d);
    chk("rate select", 11'h003, d[1:0]);
    rd(8'h07, d);
    chk("unmapped", 11'h000, d);
    $display("test rate sources done");
    wr(`ADDR_BAUD_CONTROL, 8'h01);
    i_node.bit_cyc = 32;
    for (int m = 0; m < 4; m++)
    begin
      wr(`ADDR_SERIAL_CONTROL, {2'(m), 2'h1, m[0], 3'h0});
      tx_frame(8'h3C + 8'(m), m[0], m == 1 ? 10 : 11);
    end
    $display("test frame modes done");
    wr(`ADDR_SERIAL_CONTROL, 8'h50);
    i_node.bit_cyc = 6;
    i_node.send(11'h000, 1, 99);
    i_node.bit_cyc = 32;
    i_node.idle(64);
    i_node.send({1'b1, 8'h3C, 1'b0}, 10, 3);
    i_node.idle(64);
    rx_chk(8'h3C, 3'h5);
    i_node.send({1'b1, 8'h55, 1'b0}, 10, 99);
    i_node.idle(64);
    rx_chk(8'h3C, 3'h5);
    wr(`ADDR_SERIAL_CONTROL, 8'h70);
    i_node.send({1'b0, 8'h81, 1'b0}, 10, 99);
    i_node.idle(64);
    rx_chk(8'h3C, 3'h0);
    wr(`ADDR_SERIAL_CONTROL, 8'hF0);
    i_node.send({1'b1, 1'b0, 8'h11, 1'b0}, 11, 99);
    i_node.send({1'b0, 1'b1, 8'h96, 1'b0}, 11, 99);
    i_node.idle(64);
    rx_chk(8'h96, 3'h5);
    $display("test receive done");
    stop_test();
  end
endmodule : tb
